// ==== include/cfg_access_pkg.sv ====
// constants and types shared by the root-port configuration access block
package cfg_access_pkg;

    localparam int DATA_W = 32;

    // ecam address layout
    localparam int ECAM_BUS_LSB = 20;
    localparam int ECAM_DEV_LSB = 15;
    localparam int ECAM_FN_LSB = 12;
    localparam int ECAM_REG_LSB = 2;

    // completion status codes
    localparam logic [2:0] CPL_SC = 3'h0;
    localparam logic [2:0] CPL_UR = 3'h1;
    localparam logic [2:0] CPL_CRS = 3'h2;
    localparam logic [2:0] CPL_CA = 3'h4;

    // local configuration space: word count, bus number word and fields
    localparam int LOCAL_WORDS = 16;
    localparam logic [3:0] BUSNUM_WORD = 4'h6;
    localparam int PRI_LSB = 0;
    localparam int SEC_LSB = 8;
    localparam int SUB_LSB = 16;
    localparam logic [31:0] READ_ALL_ONES = 32'hffffffff;

    // completion timeout
    localparam int CLK_PERIOD_NS = 50;
    localparam int CPL_TIMEOUT_US = 50000;
    localparam int CPL_TIMEOUT_CYCLES_DEF =
        CPL_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
    localparam int TMR_W = 21;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DECODE = 3'b001,
        ST_REQ = 3'b010,
        ST_WAIT = 3'b011,
        ST_ERR1 = 3'b100,
        ST_ERR2 = 3'b101
    } cfg_state_t;

    typedef struct packed {
        logic type1;
        logic write;
        logic [7:0] bus;
        logic [4:0] dev;
        logic [2:0] func;
        logic [9:0] regnum;
        logic [31:0] data;
    } cfg_req_t;

    typedef struct packed {
        logic [2:0] status;
        logic [31:0] data;
    } cfg_cpl_t;

    typedef struct packed {
        cfg_state_t st;
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
        cfg_req_t req;
        logic req_valid;
        logic irq;
        logic tmr_start;
        logic [LOCAL_WORDS-1:0][31:0] mem;
    } cfg_top_state_t;

    localparam cfg_top_state_t TOP_RST = '{
        st: ST_IDLE,
        hreadyout: 1'b1,
        default: '0
    };

    typedef struct packed {
        logic run;
        logic [TMR_W-1:0] cnt;
        logic expired;
    } cfg_tmr_state_t;

    localparam cfg_tmr_state_t TMR_RST = '0;

endpackage : cfg_access_pkg

// ==== rtl/cfg_cpl_timer.sv ====
// completion timer for one outstanding configuration request
`timescale 1ns/1ps
`default_nettype none
module cfg_cpl_timer #(
    parameter int LIMIT = cfg_access_pkg::CPL_TIMEOUT_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic stop,
    output logic expired
);
    import cfg_access_pkg::*;

    cfg_tmr_state_t s;
    cfg_tmr_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.expired = 1'b0;
        if (start) begin
            next_s.run = 1'b1;
            next_s.cnt = '0;
        end else if (stop) begin
            next_s.run = 1'b0;
        end else if (s.run) begin
            if (s.cnt == TMR_W'(LIMIT - 1)) begin
                // one pulse, then idle until the next request
                next_s.run = 1'b0;
                next_s.expired = 1'b1;
            end else begin
                next_s.cnt = s.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= TMR_RST;
        end else begin
            s <= next_s;
        end
    end

    assign expired = s.expired;

endmodule : cfg_cpl_timer
`default_nettype wire

// ==== rtl/cfg_access.sv ====
// root-port configuration access path: ahb-lite ecam slave to config requests
`timescale 1ns/1ps
`default_nettype none
module cfg_access #(
    parameter int CPL_TIMEOUT_CYCLES = cfg_access_pkg::CPL_TIMEOUT_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic cfg_req_valid,
    output cfg_access_pkg::cfg_req_t cfg_req,
    input wire logic cfg_req_ready,
    input wire logic cpl_valid,
    input wire cfg_access_pkg::cfg_cpl_t cpl,
    output logic cfg_timeout_irq
);
    import cfg_access_pkg::*;

    cfg_top_state_t s;
    cfg_top_state_t next_s;
    logic accept;
    logic tmr_stop;
    logic tmr_expired;
    logic [7:0] pri_bus;
    logic [7:0] sec_bus;
    logic [7:0] sub_bus;
    logic in_decode;
    logic dev_bad;
    logic route_local;
    logic route_t0;
    logic route_t1;
    logic route_err;
    logic in_flight;
    logic cpl_ok;
    logic cpl_ur;
    logic cpl_take;
    logic reg_in_range;

    ////////////////////////////////////////////////////////////////////////
    // decode of the captured address against the local header
    // bus numbers are read live, so a header write steers the next access

    assign pri_bus = s.mem[BUSNUM_WORD][PRI_LSB +: 8];
    assign sec_bus = s.mem[BUSNUM_WORD][SEC_LSB +: 8];
    assign sub_bus = s.mem[BUSNUM_WORD][SUB_LSB +: 8];
    assign in_decode = (s.st == ST_DECODE);
    assign dev_bad = in_decode && (s.req.dev != 5'h00);
    assign route_local = in_decode && !dev_bad
        && (s.req.bus == pri_bus);
    assign route_t0 = in_decode && !dev_bad && !route_local
        && (s.req.bus == sec_bus);
    assign route_t1 = in_decode && !dev_bad && !route_local
        && (s.req.bus > sec_bus) && (s.req.bus <= sub_bus);
    assign route_err = in_decode && !dev_bad && !route_local
        && !route_t0 && !route_t1;
    assign reg_in_range = (s.req.regnum < 10'(LOCAL_WORDS));

    // reserved codes fall into the unsupported class; crs is not retried
    assign cpl_ok = (cpl.status == CPL_SC);
    assign cpl_ur = !(cpl_ok || cpl.status == CPL_CRS
        || cpl.status == CPL_CA);
    assign in_flight = (s.st == ST_REQ) || (s.st == ST_WAIT);
    assign cpl_take = (s.st == ST_WAIT) && cpl_valid;
    assign tmr_stop = !in_flight;

    // a new address phase may land while the previous data phase ends
    assign accept = hsel && htrans[1] && hready
        && ((s.st == ST_IDLE) || (s.st == ST_ERR2));

    ////////////////////////////////////////////////////////////////////////
    // completion timer
    // it also runs while the request waits for ready, so a stuck link ends

    cfg_cpl_timer #(
        .LIMIT(CPL_TIMEOUT_CYCLES)
    ) u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .start(s.tmr_start),
        .stop(tmr_stop),
        .expired(tmr_expired)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_s = s;
        next_s.irq = 1'b0;
        next_s.tmr_start = 1'b0;
        unique case (s.st)
            ST_IDLE: begin
                next_s.hreadyout = 1'b1;
                next_s.hresp = 1'b0;
            end
            ST_DECODE: begin
                next_s.req.data = hwdata;
                if (route_local) begin
                    // self-configuration, nothing leaves on the link
                    if (s.req.write && reg_in_range) begin
                        next_s.mem[s.req.regnum[3:0]] = hwdata;
                    end
                    next_s.hrdata = (!s.req.write && reg_in_range)
                        ? s.mem[s.req.regnum[3:0]] : '0;
                    next_s.hreadyout = 1'b1;
                    next_s.st = ST_IDLE;
                end else if (route_t0 || route_t1) begin
                    next_s.req.type1 = route_t1;
                    next_s.req_valid = 1'b1;
                    next_s.tmr_start = 1'b1;
                    next_s.st = ST_REQ;
                end else begin
                    next_s.hresp = 1'b1;
                    next_s.hrdata = '0;
                    next_s.st = ST_ERR1;
                end
            end
            ST_REQ: begin
                if (tmr_expired) begin
                    next_s.req_valid = 1'b0;
                    next_s.hresp = 1'b1;
                    next_s.irq = 1'b1;
                    next_s.st = ST_ERR1;
                end else if (cfg_req_ready) begin
                    next_s.req_valid = 1'b0;
                    next_s.st = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // a completion in the expiry cycle still wins
                if (cpl_take) begin
                    if (!s.req.write && cpl_ok) begin
                        next_s.hrdata = cpl.data;
                        next_s.hreadyout = 1'b1;
                        next_s.st = ST_IDLE;
                    end else if (!s.req.write && cpl_ur) begin
                        next_s.hrdata = READ_ALL_ONES;
                        next_s.hreadyout = 1'b1;
                        next_s.st = ST_IDLE;
                    end else if (s.req.write && cpl_ok) begin
                        next_s.hrdata = '0;
                        next_s.hreadyout = 1'b1;
                        next_s.st = ST_IDLE;
                    end else begin
                        next_s.hrdata = '0;
                        next_s.hresp = 1'b1;
                        next_s.st = ST_ERR1;
                    end
                end else if (tmr_expired) begin
                    next_s.hrdata = '0;
                    next_s.hresp = 1'b1;
                    next_s.irq = 1'b1;
                    next_s.st = ST_ERR1;
                end
            end
            ST_ERR1: begin
                // first cycle of the two-cycle error answer
                next_s.hreadyout = 1'b1;
                next_s.st = ST_ERR2;
            end
            ST_ERR2: begin
                next_s.hresp = 1'b0;
                next_s.st = ST_IDLE;
            end
            default: begin
                next_s.hreadyout = 1'b1;
                next_s.hresp = 1'b0;
                next_s.req_valid = 1'b0;
                next_s.st = ST_IDLE;
            end
        endcase
        if (accept) begin
            // only single word transfers; hsize is not checked
            next_s.req.write = hwrite;
            next_s.req.bus = haddr[ECAM_BUS_LSB +: 8];
            next_s.req.dev = haddr[ECAM_DEV_LSB +: 5];
            next_s.req.func = haddr[ECAM_FN_LSB +: 3];
            next_s.req.regnum = haddr[ECAM_REG_LSB +: 10];
            next_s.req.type1 = 1'b0;
            next_s.hreadyout = 1'b0;
            next_s.hresp = 1'b0;
            next_s.st = ST_DECODE;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= TOP_RST;
        end else begin
            s <= next_s;
        end
    end

    assign hreadyout = s.hreadyout;
    assign hresp = s.hresp;
    assign hrdata = s.hrdata;
    assign cfg_req_valid = s.req_valid;
    assign cfg_req = s.req;
    assign cfg_timeout_irq = s.irq;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    // each assertion looks at most two cycles past its trigger; the c_type0 cover spans up to 20

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_local_answer: assert property (
        route_local |=> s.st == ST_IDLE && hreadyout && !hresp)
        else $error("local access did not finish in one cycle");

    a_local_no_req: assert property (
        route_local |=> !cfg_req_valid ##1 !cfg_req_valid)
        else $error("primary bus access reached the link");

    a_type0_req: assert property (
        route_t0 |=> cfg_req_valid && !cfg_req.type1 && !hreadyout)
        else $error("secondary bus access not sent as type 0");

    a_type1_req: assert property (
        route_t1 |=> cfg_req_valid && cfg_req.type1)
        else $error("downstream bus access not sent as type 1");

    a_busnum_update: assert property (
        route_local && s.req.write && s.req.regnum == 10'(BUSNUM_WORD)
        |=> sec_bus == $past(hwdata[SEC_LSB +: 8])
            && sub_bus == $past(hwdata[SUB_LSB +: 8]))
        else $error("bus numbers not taken from header write");

    a_range_err: assert property (
        route_err |=> (hresp && !hreadyout && !cfg_req_valid)
            ##1 (hresp && hreadyout))
        else $error("out of range bus not answered with error");

    a_ur_read_ones: assert property (
        cpl_take && !s.req.write && cpl.status == CPL_UR
        |=> hreadyout && !hresp && hrdata == READ_ALL_ONES)
        else $error("unsupported read did not return all ones");

    a_wr_ur_err: assert property (
        cpl_take && s.req.write && cpl_ur |=> hresp && !hreadyout)
        else $error("unsupported write not answered with error");

    a_dev_refused: assert property (
        dev_bad |=> (!cfg_req_valid && hresp) ##1 !cfg_req_valid)
        else $error("nonzero device not refused");

    a_nonposted: assert property (
        in_flight |-> !hreadyout)
        else $error("bus access released before completion");

    a_timeout_err: assert property (
        in_flight && tmr_expired && !cpl_take
        |=> hresp && !hreadyout ##1 hresp && hreadyout)
        else $error("timeout not answered with error");

    a_timeout_irq: assert property (
        in_flight && tmr_expired && !cpl_take
        |=> cfg_timeout_irq ##1 !cfg_timeout_irq)
        else $error("timeout interrupt not a single pulse");

    a_rsvd_as_ur: assert property (
        cpl_take && !s.req.write && cpl.status == 3'h3
        |=> hrdata == READ_ALL_ONES && !hresp)
        else $error("reserved status not handled as unsupported");

    a_addr_wait: assert property (
        accept |=> !hreadyout)
        else $error("accepted access not held in wait");

    a_req_fields: assert property (
        accept |=> cfg_req.bus == $past(haddr[ECAM_BUS_LSB +: 8])
            && cfg_req.dev == $past(haddr[ECAM_DEV_LSB +: 5])
            && cfg_req.func == $past(haddr[ECAM_FN_LSB +: 3])
            && cfg_req.regnum == $past(haddr[ECAM_REG_LSB +: 10]))
        else $error("request fields not taken from the address");

    a_req_held: assert property (
        cfg_req_valid && !cfg_req_ready && !tmr_expired
        |=> cfg_req_valid && $stable(cfg_req))
        else $error("link request dropped before it was taken");

    a_idle_no_req: assert property (
        !in_flight |-> !cfg_req_valid)
        else $error("link request outside a forwarded access");

    a_read_data: assert property (
        cpl_take && !s.req.write && cpl_ok
        |=> hreadyout && !hresp && hrdata == $past(cpl.data))
        else $error("completion data not returned to the bus");

    a_write_done: assert property (
        cpl_take && s.req.write && cpl_ok |=> hreadyout && !hresp)
        else $error("successful write not finished with okay");

    a_status_err: assert property (
        cpl_take && !s.req.write && !cpl_ok && !cpl_ur
        |=> hresp && !hreadyout)
        else $error("abort or retry status on read not an error");

    a_err_second: assert property (
        hresp && !hreadyout |=> hresp && hreadyout)
        else $error("error response not held for two cycles");

    a_irq_cause: assert property (
        !(in_flight && tmr_expired) |=> !cfg_timeout_irq)
        else $error("interrupt without a request timeout");

    c_local: cover property (route_local);
    c_type0: cover property (route_t0 ##[1:20] cpl_take);
    c_type1: cover property (route_t1);
    c_timeout: cover property (in_flight && tmr_expired);
    c_error: cover property (route_err ##2 hresp && hreadyout);

endmodule : cfg_access
`default_nettype wire

// ==== verification/cfg_completer.sv ====
// far-side model: configuration completer on the link request port
`timescale 1ns/1ps
`default_nettype none
module cfg_completer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cfg_req_valid,
    input wire cfg_access_pkg::cfg_req_t cfg_req,
    output logic cfg_req_ready,
    output logic cpl_valid,
    output cfg_access_pkg::cfg_cpl_t cpl,
    input wire logic [3:0] wait_n,
    input wire logic [2:0] status,
    input wire logic [31:0] rdata,
    input wire logic mute
);
    import cfg_access_pkg::*;
    logic busy;
    logic [3:0] cnt;
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            cnt <= 4'h0;
            cfg_req_ready <= 1'b0;
            cpl_valid <= 1'b0;
            cpl <= '0;
        end else begin
            cfg_req_ready <= 1'b0;
            cpl_valid <= 1'b0;
            // released lines toggle so stale data never looks valid
            cpl <= ~cpl;
            if (!busy && cfg_req_valid && !cfg_req_ready) begin
                cnt <= cnt + 4'h1;
                if (cnt >= wait_n) begin
                    cfg_req_ready <= 1'b1;
                    busy <= 1'b1;
                    cnt <= 4'h0;
                end
            end else if (busy) begin
                cnt <= cnt + 4'h1;
                if (cnt >= wait_n) begin
                    busy <= 1'b0;
                    cnt <= 4'h0;
                    // mute drops the completion, forcing a timeout
                    if (!mute) begin
                        cpl_valid <= 1'b1;
                        cpl <= '{status: status, data: rdata};
                    end
                end
            end
        end
    end
endmodule : cfg_completer
`default_nettype wire

// ==== verification/cfg_access_bench.sv ====
// self-checking bench for the configuration access block
`timescale 1ns/1ps
`default_nettype none
module cfg_access_bench;
    import cfg_access_pkg::*;
    typedef struct packed {logic err; logic chk; logic [31:0] data;} exp_t;
    logic clk, rst_n, hsel, hwrite, hreadyout, hresp, cfg_req_valid;
    logic cfg_req_ready, cpl_valid, cfg_timeout_irq, mute;
    logic dphase = 1'b0;
    logic [31:0] haddr, hwdata, hrdata, rdata;
    logic [1:0] htrans;
    logic [2:0] status;
    logic [3:0] wait_n;
    cfg_req_t cfg_req, rs, re;
    cfg_cpl_t cpl;
    exp_t q[$];
    exp_t e;
    cfg_req_t rq[$];
    int mismatches = 0, n_checks = 0, n_irq = 0, cycles = 0;
    ////////////////////////////////////////////////////////////////////////
    cfg_access #(.CPL_TIMEOUT_CYCLES(40)) cfg_access_i (.clk(clk),
        .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .cfg_req_valid(cfg_req_valid), .cfg_req(cfg_req),
        .cfg_req_ready(cfg_req_ready), .cpl_valid(cpl_valid), .cpl(cpl),
        .cfg_timeout_irq(cfg_timeout_irq));
    cfg_completer cfg_completer_i (.clk(clk), .rst_n(rst_n),
        .cfg_req_valid(cfg_req_valid), .cfg_req(cfg_req),
        .cfg_req_ready(cfg_req_ready), .cpl_valid(cpl_valid), .cpl(cpl),
        .wait_n(wait_n), .status(status), .rdata(rdata), .mute(mute));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t %s seen %h want %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        if (rq.size() != 0 || q.size() != 0) mismatches++;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop
    function automatic logic [31:0] ea(input logic [7:0] b,
        input logic [4:0] d, input logic [2:0] f, input logic [9:0] r);
        return {4'h0, b, d, f, r, 2'b00};
    endfunction : ea
    // one single ahb transfer; the expected answer goes to the queue
    task automatic ahb(input logic wr, input logic [31:0] a,
        input logic [31:0] d, input logic err, input logic [31:0] exp);
        q.push_back('{err, !wr && !err, exp});
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask : ahb
    // link access with completer status st, or no completion when m
    task automatic link(input logic wr, input logic [7:0] b,
        input logic t1, input logic [2:0] st, input logic m);
        logic [2:0] f;
        logic [9:0] rg;
        logic [31:0] d, rd, x;
        logic err;
        f = 3'($urandom);
        rg = 10'($urandom);
        d = $urandom;
        rd = $urandom;
        rdata <= rd;
        status <= st;
        mute <= m;
        wait_n <= 4'($urandom % 8);
        err = m || (wr ? st != CPL_SC : (st == CPL_CA || st == CPL_CRS));
        x = (st == CPL_SC) ? rd : READ_ALL_ONES;
        rq.push_back('{t1, wr, b, 5'h0, f, rg, wr ? d : 32'h0});
        ahb(wr, ea(b, 5'h0, f, rg), d, err, x);
    endtask : link
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            mismatches++;
            report_and_stop();
        end
        if (cfg_timeout_irq === 1'b1) n_irq++;
        if (dphase && hreadyout) begin
            e = (q.size() != 0) ? q.pop_front() : exp_t'{1'b1, 1'b0, 32'h0};
            check({31'h0, hresp}, {31'h0, e.err}, "resp");
            if (e.chk) check(hrdata, e.data, "rdata");
        end
        dphase <= (hsel && htrans[1] && hreadyout) || (dphase && !hreadyout);
        if (cfg_req_valid === 1'b1 && cfg_req_ready === 1'b1) begin
            rs = cfg_req;
            re = (rq.size() != 0) ? rq.pop_front() : ~rs;
            if (!rs.write) rs.data = 32'h0;
            check({4'h0, rs[59:32]}, {4'h0, re[59:32]}, "req hdr");
            check(rs.data, re.data, "req data");
        end
    end
    initial begin
        logic [31:0] r;
        {rst_n, hsel, hwrite, mute} = '0;
        {haddr, hwdata, rdata, htrans, status, wait_n} = '0;
        void'($urandom(32'h5cb7));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        ahb(1'b1, ea(8'h0, 5'h0, 3'h0, 10'h6), 32'h00040100, 1'b0, 0);
        ahb(1'b0, ea(8'h0, 5'h0, 3'h0, 10'h6), 0, 1'b0, 32'h00040100);
        r = $urandom;
        ahb(1'b1, ea(8'h0, 5'h0, 3'h0, 10'h3), r, 1'b0, 0);
        ahb(1'b0, ea(8'h0, 5'h0, 3'h0, 10'h3), 0, 1'b0, r);
        $display("test local done");
        for (int s = 0; s < 8; s++) begin
            link(1'b0, 8'h1, 1'b0, s[2:0], 1'b0);
            link(1'b1, 8'h4, 1'b1, s[2:0], 1'b0);
        end
        link(1'b1, 8'h2, 1'b1, CPL_SC, 1'b0);
        $display("test status done");
        ahb(1'b0, ea(8'h5, 5'h0, 3'h0, 10'h0), 0, 1'b1, 0);
        ahb(1'b1, ea(8'h1, 5'h3, 3'h0, 10'h0), 0, 1'b1, 0);
        ahb(1'b0, ea(8'h0, 5'h1, 3'h0, 10'h0), 0, 1'b1, 0);
        $display("test refusals done");
        link(1'b0, 8'h3, 1'b1, CPL_SC, 1'b1);
        check(n_irq, 1, "irq count");
        link(1'b1, 8'h1, 1'b0, CPL_SC, 1'b1);
        check(n_irq, 2, "irq count");
        $display("test timeout done");
        ahb(1'b1, ea(8'h0, 5'h0, 3'h0, 10'h6), 32'h00040200, 1'b0, 0);
        link(1'b0, 8'h2, 1'b0, CPL_SC, 1'b0);
        ahb(1'b0, ea(8'h1, 5'h0, 3'h0, 10'h0), 0, 1'b1, 0);
        $display("test renumber done");
        repeat (4) @(posedge clk);
        report_and_stop();
    end
endmodule : cfg_access_bench
`default_nettype wire
